// >>> core/sbc_irq_cfg.svh
// Register offsets, field masks and reset values of the interrupt register set
`ifndef SBC_IRQ_CFG_SVH
`define SBC_IRQ_CFG_SVH

// ==================================================
// Register offsets
`define SBC_ADDR_SYS_EN 7'h04
`define SBC_ADDR_SUP_EN 7'h1C
`define SBC_ADDR_TRX_EN 7'h23
`define SBC_ADDR_SUMMARY 7'h60
`define SBC_ADDR_B0_WAKE 7'h64
`define SBC_ADDR_B0_FAIL 7'h65
`define SBC_ADDR_B1_WAKE 7'h66
`define SBC_ADDR_B1_FAIL 7'h67

// ==================================================
// Writable field masks
`define SBC_SYS_EN_MASK 8'h06
`define SBC_SUP_EN_MASK 8'h3F
`define SBC_TRX_EN_MASK 8'h1F
`define SBC_TRX_LIN2_MASK 8'h08

// ==================================================
// Summary bit positions
`define SBC_SUM_SYS 0
`define SBC_SUM_SUP 1
`define SBC_SUM_TRX 2
`define SBC_SUM_B0_WAKE 3
`define SBC_SUM_B0_FAIL 4
`define SBC_SUM_B1_WAKE 5
`define SBC_SUM_B1_FAIL 6

// ==================================================
// Reset values and sizes
`define SBC_EN_RESET 8'h00
`define SBC_FLAG_RESET 8'h00
`define SBC_DATA_ZERO 8'h00
`define SBC_BANKS 4
`define SBC_PINS 8
`define SBC_PINS_PER_BANK 4

`endif

// >>> core/sbc_irq_flags.sv
// One bank of eight sticky pending flags with input synchronisers
`timescale 1ns/1ps
`include "sbc_irq_cfg.svh"

module sbc_irq_flags (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire logic [7:0] evt_async,
   input wire logic [7:0] en,
   input wire logic [7:0] clr,
   output logic [7:0] flags
);

   logic [7:0] sync1_reg;
   logic [7:0] sync2_reg;
   logic [7:0] last_reg;
   logic [7:0] edge_hit;
   logic [7:0] flags_next;

   // ==================================================
   // Synchroniser and event edge
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync1_reg <= `SBC_FLAG_RESET;
         sync2_reg <= `SBC_FLAG_RESET;
         last_reg <= `SBC_FLAG_RESET;
      end else if (ce) begin
         sync1_reg <= evt_async;
         sync2_reg <= sync1_reg;
         last_reg <= sync2_reg;
      end
   end

   assign edge_hit = sync2_reg & ~last_reg;

   // ==================================================
   // Sticky flags, set beats clear
   assign flags_next = (flags & ~clr) | (edge_hit & en);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flags <= `SBC_FLAG_RESET;
      end else if (ce) begin
         flags <= flags_next;
      end
   end

   // ==================================================
   // Checks
   chk_flag_set_wins: assert property (@(posedge clk) disable iff (reset)
      (ce && (edge_hit & en) != `SBC_FLAG_RESET)
      |=> ((flags & $past(edge_hit & en)) == $past(edge_hit & en)))
      else $error("enabled event did not set its flag");

   chk_flag_no_set: assert property (@(posedge clk) disable iff (reset)
      (ce && (edge_hit & en) == `SBC_FLAG_RESET && clr == `SBC_FLAG_RESET)
      |=> flags == $past(flags))
      else $error("flag changed without event or clear");

endmodule : sbc_irq_flags

// >>> core/sbc_irq_pkg.sv
// Types shared by the interrupt register set
package sbc_irq_pkg;

   // ==================================================
   // Register access request from the serial interface
   typedef struct packed {
      logic sel;
      logic wr;
      logic [6:0] addr;
      logic [7:0] wdata;
   } sbc_req_t;

   // ==================================================
   // Four pin status banks: 0 b0 wake, 1 b0 fail, 2 b1 wake, 3 b1 fail
   typedef logic [3:0][7:0] sbc_banks_t;

   // ==================================================
   // Pending inputs from the neighbouring status registers
   typedef struct packed {
      logic trx;
      logic sup;
      logic sys;
   } sbc_ext_pend_t;

endpackage : sbc_irq_pkg

// >>> core/sbc_irq_top.sv
// Interrupt pending flags and interrupt enable registers of the basis chip
// Notes on behaviour
// - Bank0 wake status: pin n falling at bit 2n-1, rising at bit 2n-2.
// - Bank0 fail status: pin n short at odd bit, open load at even bit.
// - Bank1 wake status: pins five to eight, falling odd, rising even bits.
// - Bank1 fail status: pins five to eight, short odd, open load even bits.
// - Status flag reads one while pending; host reads it and writes one to clear.
// - System enable: bit 2 overtemperature, bit 1 serial failure; rest reads zero.
// - Supply enable: bits 5 to 0 supply events; bits 7 and 6 read zero.
// - Transceiver enable: bits 4 to 0 bus events; bits 7 to 5 read zero.
// - Single-LIN variant: transceiver enable bit 3 is reserved and reads zero.
// - Enable bit one enables its event, zero disables; host reads and writes it.
// - Summary register shows one bit per sub-register holding a pending flag.
`timescale 1ns/1ps
`include "sbc_irq_cfg.svh"

module sbc_irq_top #(
   parameter bit DUAL_LIN = 1'b1
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   input wire sbc_irq_pkg::sbc_req_t req,
   input wire logic [7:0] pin_rise,
   input wire logic [7:0] pin_fall,
   input wire logic [7:0] pin_short,
   input wire logic [7:0] pin_open,
   input wire sbc_irq_pkg::sbc_banks_t pin_en,
   input wire sbc_irq_pkg::sbc_ext_pend_t ext_pend,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic [7:0] sys_en_reg,
   output logic [7:0] sup_en_reg,
   output logic [7:0] trx_en_reg,
   output logic irq_req
);

   sbc_irq_pkg::sbc_banks_t evt_async;
   sbc_irq_pkg::sbc_banks_t bank_clr;
   sbc_irq_pkg::sbc_banks_t flags;
   logic [7:0] summary;
   logic [7:0] rd_next;
   logic [7:0] trx_mask;
   logic wr_hit;
   logic rd_hit;
   logic [7:0] req_wdata;
   logic any_pending;

   assign wr_hit = req.sel && req.wr;
   assign rd_hit = req.sel && !req.wr;
   assign req_wdata = req.wdata;

   // ==================================================
   // Pin events into register layout
   genvar k;
   generate
      for (k = 0; k < `SBC_PINS; k = k + 1) begin : g_pin
         localparam int BK = k / `SBC_PINS_PER_BANK;
         localparam int POS = k % `SBC_PINS_PER_BANK;
         assign evt_async[2 * BK][2 * POS + 1] = pin_fall[k];
         assign evt_async[2 * BK][2 * POS] = pin_rise[k];
         assign evt_async[2 * BK + 1][2 * POS + 1] = pin_short[k];
         assign evt_async[2 * BK + 1][2 * POS] = pin_open[k];
      end
   endgenerate

   // ==================================================
   // Flag banks with write-one-to-clear
   genvar b;
   generate
      for (b = 0; b < `SBC_BANKS; b = b + 1) begin : g_bank
         assign bank_clr[b] = (wr_hit && req.addr == (`SBC_ADDR_B0_WAKE + 7'(b)))
            ? req.wdata : `SBC_DATA_ZERO;
         sbc_irq_flags u_flags (
            .clk(clk),
            .reset(reset),
            .ce(ce),
            .evt_async(evt_async[b]),
            .en(pin_en[b]),
            .clr(bank_clr[b]),
            .flags(flags[b])
         );
      end
   endgenerate

   // ==================================================
   // Enable registers
   assign trx_mask = DUAL_LIN ? `SBC_TRX_EN_MASK
      : (`SBC_TRX_EN_MASK & ~`SBC_TRX_LIN2_MASK);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sys_en_reg <= `SBC_EN_RESET;
      end else if (ce && wr_hit && req.addr == `SBC_ADDR_SYS_EN) begin
         sys_en_reg <= req.wdata & `SBC_SYS_EN_MASK;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sup_en_reg <= `SBC_EN_RESET;
      end else if (ce && wr_hit && req.addr == `SBC_ADDR_SUP_EN) begin
         sup_en_reg <= req.wdata & `SBC_SUP_EN_MASK;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         trx_en_reg <= `SBC_EN_RESET;
      end else if (ce && wr_hit && req.addr == `SBC_ADDR_TRX_EN) begin
         trx_en_reg <= req.wdata & trx_mask;
      end
   end

   // ==================================================
   // Summary of pending sub-registers
   always_comb begin
      summary = `SBC_DATA_ZERO;
      summary[`SBC_SUM_SYS] = ext_pend.sys;
      summary[`SBC_SUM_SUP] = ext_pend.sup;
      summary[`SBC_SUM_TRX] = ext_pend.trx;
      summary[`SBC_SUM_B0_WAKE] = |flags[0];
      summary[`SBC_SUM_B0_FAIL] = |flags[1];
      summary[`SBC_SUM_B1_WAKE] = |flags[2];
      summary[`SBC_SUM_B1_FAIL] = |flags[3];
   end

   // ==================================================
   // Read mux
   always_comb begin
      case (req.addr)
         `SBC_ADDR_SYS_EN: rd_next = sys_en_reg;
         `SBC_ADDR_SUP_EN: rd_next = sup_en_reg;
         `SBC_ADDR_TRX_EN: rd_next = trx_en_reg;
         `SBC_ADDR_SUMMARY: rd_next = summary;
         `SBC_ADDR_B0_WAKE: rd_next = flags[0];
         `SBC_ADDR_B0_FAIL: rd_next = flags[1];
         `SBC_ADDR_B1_WAKE: rd_next = flags[2];
         `SBC_ADDR_B1_FAIL: rd_next = flags[3];
         default: rd_next = `SBC_DATA_ZERO;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_data <= `SBC_DATA_ZERO;
         rd_valid <= 1'b0;
      end else if (ce) begin
         rd_valid <= rd_hit;
         if (rd_hit) begin
            rd_data <= rd_next;
         end
      end
   end

   // ==================================================
   // Interrupt request
   assign any_pending = |summary;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq_req <= 1'b0;
      end else if (ce) begin
         irq_req <= any_pending;
      end
   end

   // ==================================================
   // Checks
   sequence s_wr_sys;
      ce && wr_hit && req.addr == `SBC_ADDR_SYS_EN;
   endsequence

   sequence s_rd_summary;
      ce && rd_hit && req.addr == `SBC_ADDR_SUMMARY;
   endsequence

   chk_sys_en_write: assert property (@(posedge clk) disable iff (reset)
      s_wr_sys |=> sys_en_reg == ($past(req_wdata) & `SBC_SYS_EN_MASK))
      else $error("system enable write not stored");

   chk_sup_reserved: assert property (@(posedge clk) disable iff (reset)
      (sup_en_reg & ~`SBC_SUP_EN_MASK) == `SBC_DATA_ZERO)
      else $error("supply enable reserved bits set");

   chk_trx_reserved: assert property (@(posedge clk) disable iff (reset)
      (trx_en_reg & ~`SBC_TRX_EN_MASK) == `SBC_DATA_ZERO)
      else $error("transceiver enable reserved bits set");

   chk_lin2_reserved: assert property (@(posedge clk) disable iff (reset)
      !DUAL_LIN |-> (trx_en_reg & `SBC_TRX_LIN2_MASK) == `SBC_DATA_ZERO)
      else $error("second wake enable set in single variant");

   chk_summary_read: assert property (@(posedge clk) disable iff (reset)
      s_rd_summary ##1 ce |-> rd_valid && rd_data == $past(summary))
      else $error("summary read wrong");

   chk_flag_clear: assert property (@(posedge clk) disable iff (reset)
      (ce && wr_hit && req.addr == `SBC_ADDR_B0_WAKE)
      |=> (flags[0] & $past(req_wdata & ~(g_bank[0].u_flags.edge_hit & pin_en[0])))
      == `SBC_DATA_ZERO)
      else $error("written one did not clear a bank flag");

   chk_irq_follow: assert property (@(posedge clk) disable iff (reset)
      ce |=> irq_req == $past(any_pending))
      else $error("interrupt request does not follow pending flags");

   chk_en_hold: assert property (@(posedge clk) disable iff (reset)
      (!ce || !wr_hit) |=> $stable(sys_en_reg) && $stable(sup_en_reg)
      && $stable(trx_en_reg))
      else $error("enable register changed without write");

   chk_sys_reserved: assert property (@(posedge clk) disable iff (reset)
      (sys_en_reg & ~`SBC_SYS_EN_MASK) == `SBC_DATA_ZERO)
      else $error("system enable reserved bits set");

   chk_wake_read: assert property (@(posedge clk) disable iff (reset)
      (ce && rd_hit && req.addr == `SBC_ADDR_B0_WAKE) |=> rd_data == $past(flags[0]))
      else $error("bank0 wake status read wrong");

   chk_fail_read: assert property (@(posedge clk) disable iff (reset)
      (ce && rd_hit && req.addr == `SBC_ADDR_B1_FAIL) |=> rd_data == $past(flags[3]))
      else $error("bank1 fail status read wrong");

endmodule : sbc_irq_top

// >>> test/sbc_host_model.sv
// Host model issuing register requests to the interrupt block
`timescale 1ns/1ps

module sbc_host_model (
   input wire logic clk,
   output sbc_irq_pkg::sbc_req_t req,
   input wire logic [7:0] rd_data,
   input wire logic rd_valid
);
   // ==================================================
   // Request held for one rising edge, then released
   initial req = '0;

   task automatic drive(input logic w, input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      req = {1'b1, w, a, d};
      @(negedge clk);
      req = {1'b0, ~w, ~a, ~d};
   endtask : drive

   // ==================================================
   // Register write and read
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      drive(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      drive(1'b0, a, 8'h00);
      d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
   endtask : rd
endmodule : sbc_host_model

// >>> test/tb_top.sv
// Self-checking bench for the interrupt flag and enable registers
`timescale 1ns/1ps

module tb_top;
   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] wdata;
      logic [7:0] exp;
   } sbc_row_t;

   logic clk = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b1;
   sbc_irq_pkg::sbc_req_t req;
   logic [7:0] pin_rise = 8'h00, pin_fall = 8'h00, pin_short = 8'h00, pin_open = 8'h00;
   sbc_irq_pkg::sbc_banks_t pin_en = '0;
   sbc_irq_pkg::sbc_ext_pend_t ext_pend = '0;
   logic [7:0] rd_data, sys_en_reg, sup_en_reg, trx_en_reg, trx_single, got;
   logic rd_valid, irq_req;
   int err_total = 0;
   int checks_done = 0;
   int cycles = 0;
   sbc_row_t rows [6] = '{'{7'h04, 8'hFF, 8'h06}, '{7'h1C, 8'hFF, 8'h3F},
      '{7'h23, 8'hFF, 8'h1F}, '{7'h04, 8'h00, 8'h00}, '{7'h1C, 8'h2A, 8'h2A},
      '{7'h10, 8'hFF, 8'h00}};
   sbc_row_t ev [5] = '{'{7'h64, 8'h00, 8'h81}, '{7'h65, 8'h00, 8'h09},
      '{7'h66, 8'h00, 8'h10}, '{7'h67, 8'h00, 8'h81}, '{7'h60, 8'h00, 8'h78}};

   // ==================================================
   // Design, single-transceiver variant and host
   sbc_irq_top dut_u (.clk(clk), .reset(reset), .ce(ce), .req(req), .pin_rise(pin_rise),
      .pin_fall(pin_fall), .pin_short(pin_short), .pin_open(pin_open), .pin_en(pin_en),
      .ext_pend(ext_pend), .rd_data(rd_data), .rd_valid(rd_valid), .sys_en_reg(sys_en_reg),
      .sup_en_reg(sup_en_reg), .trx_en_reg(trx_en_reg), .irq_req(irq_req));
   sbc_irq_top #(.DUAL_LIN(1'b0)) dut_single_u (.clk(clk), .reset(reset), .ce(ce),
      .req(req), .pin_rise(pin_rise), .pin_fall(pin_fall), .pin_short(pin_short),
      .pin_open(pin_open), .pin_en(pin_en), .ext_pend(ext_pend), .rd_data(),
      .rd_valid(), .sys_en_reg(), .sup_en_reg(), .trx_en_reg(trx_single), .irq_req());
   sbc_host_model host_u (.clk(clk), .req(req), .rd_data(rd_data), .rd_valid(rd_valid));

   // ==================================================
   // Clock, timeout and reporting
   initial begin
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_total++;
         finish_test();
      end
   end

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test

   // ==================================================
   // Main sequence
   initial begin
      repeat (16) @(negedge clk);
      reset = 1'b0;
      chk("sys_en_reg", 8'h00, sys_en_reg);
      foreach (rows[i]) begin
         host_u.wr(rows[i].addr, rows[i].wdata);
         host_u.rd(rows[i].addr, got);
         chk("enable readback", rows[i].exp, got);
      end
      chk("trx_en_reg", 8'h1F, trx_en_reg);
      chk("single variant trx", 8'h17, trx_single);
      ce = 1'b0;
      host_u.wr(7'h04, 8'h06);
      ce = 1'b1;
      chk("frozen sys_en_reg", 8'h00, sys_en_reg);
      pin_en = {4{8'hFF}};
      @(negedge clk);
      pin_rise = 8'h41;
      pin_fall = 8'h08;
      pin_short = 8'h82;
      pin_open = 8'h11;
      repeat (6) @(negedge clk);
      foreach (ev[i]) begin
         host_u.rd(ev[i].addr, got);
         chk("pending flags", ev[i].exp, got);
      end
      chk("irq_req set", 8'h01, {7'h00, irq_req});
      host_u.wr(7'h64, 8'h01);
      host_u.wr(7'h64, 8'h00);
      host_u.rd(7'h64, got);
      chk("clear one flag", 8'h80, got);
      pin_en[0] = 8'h00;
      pin_rise = 8'h43;
      repeat (6) @(negedge clk);
      pin_en[0] = 8'hFF;
      host_u.rd(7'h64, got);
      chk("disabled event", 8'h80, got);
      host_u.wr(7'h64, 8'hFF);
      host_u.wr(7'h65, 8'hFF);
      host_u.wr(7'h66, 8'hFF);
      host_u.wr(7'h67, 8'hFF);
      repeat (2) @(negedge clk);
      chk("irq_req clear", 8'h00, {7'h00, irq_req});
      ext_pend = 3'b101;
      host_u.rd(7'h60, got);
      chk("summary ext", 8'h05, got);
      pin_rise = 8'h00;
      repeat (4) @(negedge clk);
      pin_rise = 8'h01;
      @(negedge clk);
      host_u.wr(7'h64, 8'h01);
      host_u.rd(7'h64, got);
      chk("set beats clear", 8'h01, got);
      host_u.wr(7'h1C, 8'h3F);
      {pin_rise, pin_fall, pin_short, pin_open} = 32'h00000000;
      reset = 1'b1;
      repeat (2) @(negedge clk);
      chk("sup_en_reg reset", 8'h00, sup_en_reg);
      reset = 1'b0;
      repeat (2) @(negedge clk);
      chk("irq_req after reset", 8'h01, {7'h00, irq_req});
      host_u.rd(7'h60, got);
      chk("summary after reset", 8'h05, got);
      finish_test();
   end
endmodule : tb_top
